// >>> hdl/lair_level_decode.sv
// Level code decoder for one line input into the left gain mixer.
// Takes the bank's next code, unregistered, at its input; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module lair_level_decode (
	// Code
	input wire logic [3:0] code,
	// Decoded
	output logic connected,
	output logic [4:0] atten_half_db
);
	import lair_pkg::*;
	// Reserved codes are treated as disconnected so that no odd gain leaks out
	always_comb begin
		connected = (code <= LAIR_LVL_MIN);
		atten_half_db = 5'h00;
		if (connected) begin
			atten_half_db = 5'(code) * 5'(LAIR_HALF_DB_PER_CODE);
		end
	end
endmodule
`default_nettype wire

// >>> hdl/lair_pkg.sv
// Package: register map, field layout and carrier types of the left ADC
// line-input routing bank. Assumes a 32-bit AHB-Lite fabric.
package lair_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] LAIR_IDX_ONE = 8'h13;
	localparam logic [7:0] LAIR_IDX_TWO = 8'h14;
	localparam logic [9:0] LAIR_ADDR_ONE = {LAIR_IDX_ONE, 2'h0};
	localparam logic [9:0] LAIR_ADDR_TWO = {LAIR_IDX_TWO, 2'h0};
	localparam int LAIR_ADDR_W = 10;
	// Field positions
	localparam int LAIR_MODE_BIT = 7;
	localparam int LAIR_LVL_HI = 6;
	localparam int LAIR_LVL_LO = 3;
	localparam int LAIR_PWR_BIT = 2;
	localparam int LAIR_BIAS_BIT = 2;
	localparam int LAIR_STEP_HI = 1;
	localparam int LAIR_STEP_LO = 0;
	// Reset values
	localparam logic [7:0] LAIR_RST_ONE = 8'h78;
	localparam logic [7:0] LAIR_RST_TWO = 8'h78;
	localparam logic [7:0] LAIR_TWO_WMASK = 8'hfc;
	// Level codes
	localparam logic [3:0] LAIR_LVL_OFF = 4'hf;
	localparam logic [3:0] LAIR_LVL_MIN = 4'h8;
	localparam logic [2:0] LAIR_HALF_DB_PER_CODE = 3'h3;
	typedef enum logic [1:0] {
		LAIR_STEP_EVERY = 2'b00,
		LAIR_STEP_EVERY_TWO = 2'b01,
		LAIR_STEP_OFF_A = 2'b10,
		LAIR_STEP_OFF_B = 2'b11
	} lair_step_t;
	localparam logic [1:0] LAIR_HTRANS_NONSEQ = 2'h2;
	localparam logic [31:0] LAIR_RDATA_ZERO = 32'h0000_0000;
	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic [31:0] hwdata;
		logic hready;
	} lair_ahb_in_t;
	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} lair_ahb_out_t;
	typedef struct packed {
		logic one_diff;
		logic [3:0] one_level;
		logic one_connected;
		logic [4:0] one_atten_half_db;
		logic adc_power_up;
		logic [1:0] step_mode;
		logic two_diff;
		logic [3:0] two_level;
		logic two_connected;
		logic [4:0] two_atten_half_db;
		logic weak_bias_en;
	} lair_route_t;
endpackage

// >>> hdl/lair_regs.sv
// Left ADC line-input routing register bank with an AHB-Lite slave.
// Assumes one master, single word transfers, sample_tick from ref_clk logic.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module lair_regs (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register bus
	input wire lair_pkg::lair_ahb_in_t ahb_in,
	output lair_pkg::lair_ahb_out_t ahb_out,
	// Sample pace
	input wire logic sample_tick,
	output logic step_pulse,
	// Analogue controls
	output lair_pkg::lair_route_t route
);
	import lair_pkg::*;

	typedef struct packed {
		logic dp_valid;
		logic dp_write;
		logic dp_one;
		logic dp_two;
		logic [7:0] reg_one;
		logic [7:0] reg_two;
		logic [31:0] rdata;
		logic ready;
		lair_route_t route;
	} lair_state_t;

	lair_state_t st_reg, st_next;

	logic ap_take;
	logic ap_one;
	logic ap_two;
	logic [7:0] one_val;
	logic [7:0] two_val;
	logic one_conn;
	logic two_conn;
	logic [4:0] one_att;
	logic [4:0] two_att;

	// Address phase is taken only with hready high
	assign ap_take = ahb_in.hsel && ahb_in.hready && ahb_in.htrans[1];
	assign ap_one = (ahb_in.haddr[LAIR_ADDR_W-1:0] == LAIR_ADDR_ONE)
		&& (ahb_in.haddr[31:LAIR_ADDR_W] == '0);
	assign ap_two = (ahb_in.haddr[LAIR_ADDR_W-1:0] == LAIR_ADDR_TWO)
		&& (ahb_in.haddr[31:LAIR_ADDR_W] == '0);

	// Register values after any write in the current data phase
	always_comb begin
		one_val = st_reg.reg_one;
		two_val = st_reg.reg_two;
		if (st_reg.dp_valid && st_reg.dp_write) begin
			if (st_reg.dp_one) begin
				one_val = ahb_in.hwdata[7:0];
			end
			if (st_reg.dp_two) begin
				// Reserved low bits never stored, so they always read zero
				two_val = ahb_in.hwdata[7:0] & LAIR_TWO_WMASK;
			end
		end
	end

	lair_level_decode u_dec_one (
		.code(one_val[LAIR_LVL_HI:LAIR_LVL_LO]),
		.connected(one_conn),
		.atten_half_db(one_att)
	);

	lair_level_decode u_dec_two (
		.code(two_val[LAIR_LVL_HI:LAIR_LVL_LO]),
		.connected(two_conn),
		.atten_half_db(two_att)
	);

	always_comb begin
		st_next = st_reg;
		st_next.ready = 1'b1;
		st_next.dp_valid = ap_take;
		st_next.dp_write = ap_take && ahb_in.hwrite;
		st_next.dp_one = ap_take && ap_one;
		st_next.dp_two = ap_take && ap_two;
		st_next.reg_one = one_val;
		st_next.reg_two = two_val;
		// Reads forward a write still in its data phase
		st_next.rdata = LAIR_RDATA_ZERO;
		if (ap_take && !ahb_in.hwrite) begin
			if (ap_one) begin
				st_next.rdata = {24'h000000, one_val};
			end else if (ap_two) begin
				st_next.rdata = {24'h000000, two_val};
			end
		end
		st_next.route.one_diff = one_val[LAIR_MODE_BIT];
		st_next.route.one_level = one_val[LAIR_LVL_HI:LAIR_LVL_LO];
		st_next.route.one_connected = one_conn;
		st_next.route.one_atten_half_db = one_att;
		st_next.route.adc_power_up = one_val[LAIR_PWR_BIT];
		st_next.route.step_mode = one_val[LAIR_STEP_HI:LAIR_STEP_LO];
		st_next.route.two_diff = two_val[LAIR_MODE_BIT];
		st_next.route.two_level = two_val[LAIR_LVL_HI:LAIR_LVL_LO];
		st_next.route.two_connected = two_conn;
		st_next.route.two_atten_half_db = two_att;
		st_next.route.weak_bias_en = two_val[LAIR_BIAS_BIT];
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.ready <= 1'b1;
			st_reg.reg_one <= LAIR_RST_ONE;
			st_reg.reg_two <= LAIR_RST_TWO;
			st_reg.route.one_level <= LAIR_LVL_OFF;
			st_reg.route.two_level <= LAIR_LVL_OFF;
		end else begin
			st_reg <= st_next;
		end
	end

	lair_step_pacer u_pacer (
		.ref_clk(ref_clk),
		.rst(rst),
		.sample_tick(sample_tick),
		.step_mode(st_reg.route.step_mode),
		.step_pulse(step_pulse)
	);

	// Zero wait states; errors are never signalled
	assign ahb_out.hrdata = st_reg.rdata;
	assign ahb_out.hreadyout = st_reg.ready;
	assign ahb_out.hresp = 1'b0;
	assign route = st_reg.route;

	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	logic wr_one_dp;
	logic wr_two_dp;
	logic rd_two_dp;
	logic rd_one_dp;
	logic rd_dp;
	assign wr_one_dp = st_reg.dp_valid && st_reg.dp_write && st_reg.dp_one;
	assign wr_two_dp = st_reg.dp_valid && st_reg.dp_write && st_reg.dp_two;
	assign rd_two_dp = st_reg.dp_valid && !st_reg.dp_write && st_reg.dp_two;
	assign rd_one_dp = st_reg.dp_valid && !st_reg.dp_write && st_reg.dp_one;
	assign rd_dp = st_reg.dp_valid && !st_reg.dp_write;

	a_reset_defaults: assert property (
		$past(rst) |-> (st_reg.reg_one == LAIR_RST_ONE)
			&& (st_reg.reg_two == LAIR_RST_TWO)
			&& !route.one_connected && !route.two_connected
			&& !route.adc_power_up)
		else $error("Routing registers not at defaults after reset");

	a_one_mode_follow: assert property (
		wr_one_dp |=> route.one_diff == $past(ahb_in.hwdata[LAIR_MODE_BIT]))
		else $error("Line one mode does not follow write");

	a_one_gain_map: assert property (
		route.one_connected |-> route.one_atten_half_db
			== 5'(route.one_level) * 5'(LAIR_HALF_DB_PER_CODE))
		else $error("Line one attenuation does not match code");

	a_level_off_disc: assert property (
		(route.one_level == LAIR_LVL_OFF) |-> !route.one_connected)
		else $error("Code 1111 left line one connected");

	a_write_connects: assert property (
		wr_one_dp && (ahb_in.hwdata[LAIR_LVL_HI:LAIR_LVL_LO] <= LAIR_LVL_MIN)
			|=> route.one_connected ##1 route.one_connected
			|| $past(ahb_out.hreadyout) && st_reg.dp_valid)
		else $error("Gain write did not connect line one");

	a_power_follow: assert property (
		wr_one_dp |=> route.adc_power_up == $past(ahb_in.hwdata[LAIR_PWR_BIT]))
		else $error("Power control does not follow write");

	a_step_off_quiet: assert property (
		route.step_mode[1] && $past(route.step_mode[1]) |-> !step_pulse)
		else $error("Soft step pulse while disabled");

	a_step_every: assert property (
		(route.step_mode == LAIR_STEP_EVERY) && sample_tick
			&& $stable(route.step_mode) |=> step_pulse)
		else $error("Missed soft step on sample");

	a_step_every_two: assert property (
		step_pulse && (route.step_mode == LAIR_STEP_EVERY_TWO)
			&& $stable(route.step_mode) && sample_tick |=> !step_pulse)
		else $error("Soft step pace too fast");

	a_two_mode_follow: assert property (
		wr_two_dp |=> route.two_diff == $past(ahb_in.hwdata[LAIR_MODE_BIT]))
		else $error("Line two mode does not follow write");

	a_two_level_map: assert property (
		route.two_connected == (route.two_level <= LAIR_LVL_MIN))
		else $error("Line two connection does not match code");

	a_bias_follow: assert property (
		wr_two_dp |=> route.weak_bias_en == $past(ahb_in.hwdata[LAIR_BIAS_BIT]))
		else $error("Weak bias does not follow write");

	a_reserved_zero: assert property (
		rd_two_dp |-> ahb_out.hrdata[LAIR_STEP_HI:LAIR_STEP_LO] == 2'h0)
		else $error("Reserved bits read nonzero");

	a_read_back_one: assert property (
		rd_one_dp |-> ahb_out.hrdata[7:0] == st_reg.reg_one)
		else $error("Read back of first register wrong");

	a_bus_okay: assert property (
		ahb_out.hreadyout && !ahb_out.hresp)
		else $error("Bus answer not ready and OKAY");

	a_reset_route: assert property (
		$past(rst) |-> (route.one_level == LAIR_LVL_OFF)
			&& (route.two_level == LAIR_LVL_OFF)
			&& !route.one_diff && !route.two_diff
			&& !route.weak_bias_en && !step_pulse
			&& (route.step_mode == LAIR_STEP_EVERY)
			&& (ahb_out.hrdata == LAIR_RDATA_ZERO))
		else $error("Route outputs not at defaults after reset");

	a_one_conn_map: assert property (
		route.one_connected == (route.one_level <= LAIR_LVL_MIN))
		else $error("Line one connection does not match code");

	a_one_disc_atten: assert property (
		!route.one_connected |-> route.one_atten_half_db == 5'h00)
		else $error("Disconnected line one has attenuation");

	a_one_atten_range: assert property (
		route.one_atten_half_db
			<= 5'(LAIR_LVL_MIN) * 5'(LAIR_HALF_DB_PER_CODE))
		else $error("Line one attenuation beyond lowest gain");

	a_one_level_follow: assert property (
		wr_one_dp |=> route.one_level
			== $past(ahb_in.hwdata[LAIR_LVL_HI:LAIR_LVL_LO]))
		else $error("Line one level does not follow write");

	a_write_disconnects: assert property (
		wr_one_dp && (ahb_in.hwdata[LAIR_LVL_HI:LAIR_LVL_LO] == LAIR_LVL_OFF)
			|=> !route.one_connected)
		else $error("Off code left line one connected");

	a_step_follow: assert property (
		wr_one_dp |=> route.step_mode
			== $past(ahb_in.hwdata[LAIR_STEP_HI:LAIR_STEP_LO]))
		else $error("Soft step code does not follow write");

	a_step_on_tick: assert property (
		step_pulse |-> $past(sample_tick))
		else $error("Soft step pulse without a sample tick");

	a_one_write_iso: assert property (
		wr_one_dp |=> $stable(route.two_level) && $stable(route.two_diff)
			&& $stable(route.weak_bias_en))
		else $error("Line one write disturbed line two");

	a_two_gain_map: assert property (
		route.two_connected |-> route.two_atten_half_db
			== 5'(route.two_level) * 5'(LAIR_HALF_DB_PER_CODE))
		else $error("Line two attenuation does not match code");

	a_two_disc_atten: assert property (
		!route.two_connected |-> route.two_atten_half_db == 5'h00)
		else $error("Disconnected line two has attenuation");

	a_two_atten_range: assert property (
		route.two_atten_half_db
			<= 5'(LAIR_LVL_MIN) * 5'(LAIR_HALF_DB_PER_CODE))
		else $error("Line two attenuation beyond lowest gain");

	a_two_level_follow: assert property (
		wr_two_dp |=> route.two_level
			== $past(ahb_in.hwdata[LAIR_LVL_HI:LAIR_LVL_LO]))
		else $error("Line two level does not follow write");

	a_two_write_conn: assert property (
		wr_two_dp && (ahb_in.hwdata[LAIR_LVL_HI:LAIR_LVL_LO] <= LAIR_LVL_MIN)
			|=> route.two_connected)
		else $error("Gain write did not connect line two");

	a_two_write_disc: assert property (
		wr_two_dp && (ahb_in.hwdata[LAIR_LVL_HI:LAIR_LVL_LO] == LAIR_LVL_OFF)
			|=> !route.two_connected)
		else $error("Off code left line two connected");

	a_two_write_iso: assert property (
		wr_two_dp |=> $stable(route.one_level) && $stable(route.one_diff)
			&& $stable(route.adc_power_up)
			&& $stable(route.step_mode))
		else $error("Line two write disturbed line one");

	a_two_low_kept: assert property (
		st_reg.reg_two[LAIR_STEP_HI:LAIR_STEP_LO] == 2'h0)
		else $error("Reserved bits of second register stored");

	a_read_back_two: assert property (
		rd_two_dp |-> ahb_out.hrdata[7:0] == st_reg.reg_two)
		else $error("Read back of second register wrong");

	a_read_upper_zero: assert property (
		rd_dp |-> ahb_out.hrdata[31:8] == '0)
		else $error("Upper read data bits nonzero");

	a_rdata_idle_zero: assert property (
		!rd_dp |-> ahb_out.hrdata == LAIR_RDATA_ZERO)
		else $error("Read data nonzero outside a read");

	a_unmapped_zero: assert property (
		rd_dp && !st_reg.dp_one && !st_reg.dp_two |-> ahb_out.hrdata == LAIR_RDATA_ZERO)
		else $error("Unmapped read returned data");

	a_route_hold: assert property (
		!wr_one_dp && !wr_two_dp |=> $stable(route))
		else $error("Route changed without a write");

	c_write_one: cover property (wr_one_dp ##1 route.one_connected);
	c_write_two_bias: cover property (wr_two_dp ##1 route.weak_bias_en);
	c_step_two: cover property (
		(route.step_mode == LAIR_STEP_EVERY_TWO) && step_pulse);
	c_read_two: cover property (rd_two_dp);
	c_two_disc: cover property (wr_two_dp ##1 !route.two_connected);
endmodule
`default_nettype wire

// >>> hdl/lair_step_pacer.sv
// Soft-step pacer for the left gain stage.
// Assumes sample_tick is a one-cycle pulse per sample from ref_clk logic.
`timescale 1ns/10ps
`default_nettype none
module lair_step_pacer (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Control
	input wire logic sample_tick,
	input wire logic [1:0] step_mode,
	// Pace
	output logic step_pulse
);
	import lair_pkg::*;
	typedef struct packed {
		logic odd;
		logic pulse;
	} lair_pace_st_t;
	lair_pace_st_t st_reg, st_next;
	always_comb begin
		st_next = st_reg;
		st_next.pulse = 1'b0;
		case (lair_step_t'(step_mode))
			LAIR_STEP_EVERY: begin
				st_next.odd = 1'b0;
				st_next.pulse = sample_tick;
			end
			LAIR_STEP_EVERY_TWO: begin
				if (sample_tick) begin
					st_next.odd = !st_reg.odd;
					st_next.pulse = st_reg.odd;
				end
			end
			default: begin
				st_next.odd = 1'b0;
			end
		endcase
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign step_pulse = st_reg.pulse;
endmodule
`default_nettype wire

// >>> verif/lair_regs_bench.sv
// Self-checking bench for the left ADC line-input routing register bank.
// Assumes the bank answers with zero wait states; the bench still waits on hreadyout.
`timescale 1ns/10ps
`default_nettype none
module lair_regs_bench;
	import lair_pkg::*;
	logic ref_clk;
	logic rst;
	logic sample_tick;
	logic step_pulse;
	lair_ahb_in_t m;
	lair_ahb_in_t ahb_in;
	lair_ahb_out_t ahb_out;
	lair_route_t route;
	integer seed;
	int bad_count;
	int comparisons;
	int cycles;
	int pulses;
	logic [7:0] sh_one;
	logic [7:0] sh_two;

	lair_regs DUT (
		.ref_clk(ref_clk),
		.rst(rst),
		.ahb_in(ahb_in),
		.ahb_out(ahb_out),
		.sample_tick(sample_tick),
		.step_pulse(step_pulse),
		.route(route)
	);

	// Single slave, so the bus hready is its own hreadyout
	always_comb begin
		ahb_in = m;
		ahb_in.hready = ahb_out.hreadyout;
	end

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Ceiling well above the few hundred cycles the sequence needs
	always @(posedge ref_clk) begin
		if (step_pulse === 1'b1) begin
			pulses++;
		end
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			close_out();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_ready();
		do @(posedge ref_clk); while (ahb_out.hreadyout !== 1'b1);
	endtask

	// One single word transfer; entered just after a rising edge
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r);
		m.hsel <= 1'b1;
		m.haddr <= a;
		m.htrans <= LAIR_HTRANS_NONSEQ;
		m.hwrite <= w;
		m.hsize <= 3'h2;
		wait_ready();
		m.hsel <= 1'b0;
		m.htrans <= 2'h0;
		m.hwdata <= d;
		wait_ready();
		r = ahb_out.hrdata;
		chk("hresp", 32'h0, 32'(ahb_out.hresp));
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask

	function automatic logic [5:0] lvl(input logic [3:0] c);
		return (c <= 4'h8) ? {1'b1, 5'(c) * 5'h3} : 6'h00;
	endfunction

	function automatic lair_route_t exp_route(input logic [7:0] a, input logic [7:0] b);
		lair_route_t e;
		e = '0;
		e.one_diff = a[7];
		e.one_level = a[6:3];
		{e.one_connected, e.one_atten_half_db} = lvl(a[6:3]);
		e.adc_power_up = a[2];
		e.step_mode = a[1:0];
		e.two_diff = b[7];
		e.two_level = b[6:3];
		{e.two_connected, e.two_atten_half_db} = lvl(b[6:3]);
		e.weak_bias_en = b[2];
		return e;
	endfunction

	// Route is looked at once the write edge has landed, then both words read back
	task automatic chk_all();
		logic [31:0] r;
		@(negedge ref_clk);
		chk("route", 32'(exp_route(sh_one, sh_two)), 32'(route));
		@(posedge ref_clk);
		bus(32'(LAIR_ADDR_ONE), 1'b0, 32'h0, r);
		chk("reg_one", {24'h0, sh_one}, r);
		bus(32'(LAIR_ADDR_TWO), 1'b0, 32'h0, r);
		chk("reg_two", {24'h0, sh_two}, r);
	endtask

	initial begin
		logic [31:0] rnd;
		logic [31:0] d;
		logic [3:0] code;
		seed = 73240;
		m = '0;
		sample_tick = 1'b0;
		rst = 1'b1;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		sh_one = LAIR_RST_ONE;
		sh_two = LAIR_RST_TWO;
		chk_all();
		// Every gain code and the disconnect code on both inputs, random mode bits
		for (int i = 0; i < 10; i++) begin
			code = (i == 9) ? 4'hf : 4'(i);
			rnd = $random(seed);
			d = {rnd[31:8], rnd[7], code, rnd[2:0]};
			wr(32'(LAIR_ADDR_ONE), d);
			sh_one = d[7:0];
			code = (i == 9) ? 4'hf : 4'(8 - i);
			rnd = $random(seed);
			d = {rnd[31:8], rnd[7], code, rnd[2:0]};
			wr(32'(LAIR_ADDR_TWO), d);
			sh_two = {d[7:2], 2'b00};
			chk_all();
		end
		// Unmapped words: no effect, read as zero
		// Right line one word: its mode stays single-ended, as on its other path
		wr(32'h0000_0054, 32'hffff_ff78);
		wr(32'h0000_044c, 32'hffff_ffff);
		bus(32'h0000_0054, 1'b0, 32'h0, d);
		chk("unmapped", 32'h0, d);
		chk_all();
		// Soft-step pace, all four codes, eight ticks each
		for (int md = 0; md < 4; md++) begin
			sh_one = {sh_one[7:2], 2'(md)};
			wr(32'(LAIR_ADDR_ONE), {24'h0, sh_one});
			repeat (2) @(posedge ref_clk);
			@(negedge ref_clk);
			pulses = 0;
			repeat (8) begin
				@(posedge ref_clk);
				sample_tick <= 1'b1;
				@(posedge ref_clk);
				sample_tick <= 1'b0;
				repeat (($random(seed) & 3) + 1) @(posedge ref_clk);
			end
			repeat (3) @(posedge ref_clk);
			@(negedge ref_clk);
			chk("step_pulses", (md == 0) ? 8 : (md == 1) ? 4 : 0, pulses);
			@(posedge ref_clk);
		end
		// Reset in mid-run restores the defaults
		wr(32'(LAIR_ADDR_TWO), 32'h0000_0084);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		sh_one = LAIR_RST_ONE;
		sh_two = LAIR_RST_TWO;
		chk_all();
		close_out();
	end
endmodule
`default_nettype wire
